// ===== stats_pkg.sv
// shared constants for the statistics counter bank
package stats_pkg;
	localparam int COUNTER_COUNT = 12;
	localparam int COUNTER_WIDTH = 32;
	localparam int INDEX_WIDTH = 4;
	// counter byte offsets inside the dump image
	localparam logic [7:0] OFS_TX_GOOD = 8'h00;
	localparam logic [7:0] OFS_RETRY_LIMIT = 8'h04;
	localparam logic [7:0] OFS_LATE_COL = 8'h08;
	localparam logic [7:0] OFS_UNDERRUN = 8'h0C;
	localparam logic [7:0] OFS_LOST_CRS = 8'h10;
	localparam logic [7:0] OFS_DEFERRED = 8'h14;
	localparam logic [7:0] OFS_SINGLE_COL = 8'h18;
	localparam logic [7:0] OFS_MULTI_COL = 8'h1C;
	localparam logic [7:0] OFS_TOTAL_COL = 8'h20;
	localparam logic [7:0] OFS_RX_GOOD = 8'h24;
	localparam logic [7:0] OFS_CRC_ERR = 8'h28;
	localparam logic [7:0] OFS_ALIGN_ERR = 8'h2C;
	// counter indices
	localparam logic [3:0] IDX_TX_GOOD = 4'h0;
	localparam logic [3:0] IDX_RETRY_LIMIT = 4'h1;
	localparam logic [3:0] IDX_LATE_COL = 4'h2;
	localparam logic [3:0] IDX_UNDERRUN = 4'h3;
	localparam logic [3:0] IDX_LOST_CRS = 4'h4;
	localparam logic [3:0] IDX_DEFERRED = 4'h5;
	localparam logic [3:0] IDX_SINGLE_COL = 4'h6;
	localparam logic [3:0] IDX_MULTI_COL = 4'h7;
	localparam logic [3:0] IDX_TOTAL_COL = 4'h8;
	localparam logic [3:0] IDX_RX_GOOD = 4'h9;
	localparam logic [3:0] IDX_CRC_ERR = 4'hA;
	localparam logic [3:0] IDX_ALIGN_ERR = 4'hB;
	localparam logic [3:0] IDX_LAST = 4'hB;
	localparam logic [31:0] COUNTER_RESET = 32'h00000000;
	localparam logic [3:0] COLL_WIDTH_ONE = 4'h1;
	localparam logic [3:0] COLL_ZERO = 4'h0;
	localparam logic [3:0] OPC_DUMP = 4'h5;
	localparam logic [3:0] OPC_DUMP_RESET = 4'h7;
	localparam logic [31:0] ADDR_RESET = 32'h00000000;
endpackage

// ===== stats_event_if.sv
// frame completion events between the capture stage and the counter bank
`timescale 1ns/1ps
`default_nettype none
interface stats_event_if;
	logic [stats_pkg::COUNTER_COUNT-1:0] inc;
	logic [3:0] coll_add;
	logic clear_all;
	logic [stats_pkg::INDEX_WIDTH-1:0] rd_index;
	logic [31:0] rd_data;
	modport ctrl (output inc, output coll_add, output clear_all, output rd_index, input rd_data);
	modport bank (input inc, input coll_add, input clear_all, input rd_index, output rd_data);
endinterface
`default_nettype wire

// ===== stats_counter_bank.sv
// twelve wrapping 32-bit counters with a registered read port
`timescale 1ns/1ps
`default_nettype none
module stats_counter_bank (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// event and read side
	stats_event_if.bank ev
);
	logic [31:0] count_r [stats_pkg::COUNTER_COUNT];
	logic [31:0] rd_data_r;

	////////////////////////////////////////////////////////////////
	// counters: free wrap past all ones, clear only to zero
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < stats_pkg::COUNTER_COUNT; i++) begin
				count_r[i] <= stats_pkg::COUNTER_RESET; // R17
			end
		end else begin
			for (int i = 0; i < stats_pkg::COUNTER_COUNT; i++) begin
				if (ev.clear_all) begin
					count_r[i] <= stats_pkg::COUNTER_RESET; // R19
				end else if (i == int'(stats_pkg::IDX_TOTAL_COL)) begin
					count_r[i] <= count_r[i] + {28'h0000000, ev.coll_add}; // R11 R16
				end else if (ev.inc[i]) begin
					count_r[i] <= count_r[i] + 32'h00000001; // R16
				end
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_data_r <= stats_pkg::COUNTER_RESET;
		end else begin
			rd_data_r <= count_r[ev.rd_index];
		end
	end

	assign ev.rd_data = rd_data_r;
endmodule // stats_counter_bank
`default_nettype wire

// ===== mac_statistics_counters.sv
// network statistics counter bank with dump engine
//
// Behaviour
// R1 - counters update only when frame processing ends
// R2 - counters reach software only through dump commands
// R3 - offset 0 counts frames done on link
// R4 - offset 4 counts retry limit drops
// R5 - offset 8 counts late collision drops
// R6 - offset 12 counts underruns, maybe repeatedly
// R7 - offset 16 counts frames with lost carrier
// R8 - offset 20 counts deferred frames
// R9 - offset 24 counts exactly one collision success
// R10 - offset 28 counts multi collision successes
// R11 - offset 32 adds every transmit collision
// R12 - offset 36 counts good frames stored fully
// R13 - offset 40 counts aligned crc errors once
// R14 - offset 44 counts misaligned crc errors
// R15 - crc, alignment, short classes are exclusive
// R16 - counters are 32 bits, wrap silently
// R17 - reset clears all counters, no preload
// R18 - one frame may bump several counters
// R19 - dump writes words, dump-reset then clears
// R20 - events during dump are never lost; code holds one pending event per flag counter, collisions in 4 bits
`timescale 1ns/1ps
`default_nettype none
module mac_statistics_counters (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// transmit completion, one-cycle strobe at end of link transmission
	input wire logic tx_done,
	input wire logic tx_ok,
	input wire logic tx_retry_limit,
	input wire logic tx_late_collision,
	input wire logic tx_lost_carrier,
	input wire logic tx_deferred,
	input wire logic [3:0] tx_collisions,
	// underrun strobe, once per underrun attempt
	input wire logic tx_underrun,
	// receive completion, strobe after last byte stored in memory
	input wire logic rx_done,
	input wire logic rx_ok,
	input wire logic rx_crc_error,
	input wire logic rx_misaligned,
	input wire logic rx_short,
	input wire logic rx_symbol_error,
	// command unit
	input wire logic load_dump_addr,
	input wire logic [31:0] general_pointer,
	input wire logic cmd_valid,
	input wire logic [3:0] command_unit_opcode,
	// dump write port toward memory
	output logic wr_valid,
	output logic [31:0] wr_addr,
	output logic [31:0] wr_data,
	input wire logic wr_ready,
	output logic dump_busy,
	output logic dump_done
);
	typedef enum logic [1:0] {IDLE, READ, WRITE, FINISH} dump_state_type;

	stats_event_if ev ();
	stats_counter_bank u_bank (.core_clk(core_clk), .reset(reset), .ev(ev));

	dump_state_type state_r;
	logic [3:0] index_r;
	logic reset_after_r;
	logic [31:0] dump_addr_r;
	logic wr_valid_r;
	logic [31:0] wr_addr_r;
	logic [31:0] wr_data_r;
	logic dump_done_r;
	logic [11:0] inc_nxt;
	logic [3:0] coll_nxt;
	logic freeze;
	logic [11:0] held_inc_r;
	logic [3:0] held_coll_r;

	function automatic logic [31:0] word_addr(input logic [31:0] base, input logic [3:0] idx);
		word_addr = base + {26'h0, idx, 2'b00};
	endfunction

	////////////////////////////////////////////////////////////////
	// classify frame end strobes into counter increments
	always_comb begin
		logic crc_class;
		logic align_class;
		crc_class = rx_done && !rx_short && !rx_misaligned && (rx_crc_error || rx_symbol_error); // R13 R15
		align_class = rx_done && !rx_short && rx_misaligned && rx_crc_error; // R14 R15
		inc_nxt = '0;
		inc_nxt[stats_pkg::IDX_TX_GOOD] = tx_done && tx_ok; // R1 R3
		inc_nxt[stats_pkg::IDX_RETRY_LIMIT] = tx_done && tx_retry_limit; // R4
		inc_nxt[stats_pkg::IDX_LATE_COL] = tx_done && tx_late_collision; // R5
		inc_nxt[stats_pkg::IDX_UNDERRUN] = tx_underrun; // R6
		inc_nxt[stats_pkg::IDX_LOST_CRS] = tx_done && tx_ok && tx_lost_carrier; // R7 R18
		inc_nxt[stats_pkg::IDX_DEFERRED] = tx_done && tx_deferred; // R8 R18
		inc_nxt[stats_pkg::IDX_SINGLE_COL] = tx_done && tx_ok
			&& tx_collisions == stats_pkg::COLL_WIDTH_ONE; // R9
		inc_nxt[stats_pkg::IDX_MULTI_COL] = tx_done && tx_ok
			&& tx_collisions > stats_pkg::COLL_WIDTH_ONE; // R10
		inc_nxt[stats_pkg::IDX_RX_GOOD] = rx_done && rx_ok; // R12
		inc_nxt[stats_pkg::IDX_CRC_ERR] = crc_class; // R13
		inc_nxt[stats_pkg::IDX_ALIGN_ERR] = align_class; // R14
		coll_nxt = tx_done ? tx_collisions : stats_pkg::COLL_ZERO; // R11
	end

	////////////////////////////////////////////////////////////////
	// events during a dump are held, then applied after the snapshot
	// only one pending event per flag counter fits, held collisions add in 4 bits; frames are far longer than a dump
	assign freeze = (state_r != IDLE);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			held_inc_r <= '0;
			held_coll_r <= stats_pkg::COLL_ZERO;
		end else if (freeze) begin
			held_inc_r <= held_inc_r | inc_nxt; // R20
			held_coll_r <= 4'(held_coll_r + coll_nxt); // R20
		end else begin
			held_inc_r <= '0;
			held_coll_r <= stats_pkg::COLL_ZERO;
		end
	end

	assign ev.inc = freeze ? '0 : (inc_nxt | held_inc_r); // R20 R18
	assign ev.coll_add = freeze ? stats_pkg::COLL_ZERO : 4'(coll_nxt + held_coll_r); // R11 R20
	assign ev.clear_all = (state_r == FINISH) && reset_after_r; // R19
	assign ev.rd_index = index_r;

	////////////////////////////////////////////////////////////////
	// dump address and dump sequencer
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dump_addr_r <= stats_pkg::ADDR_RESET;
		end else if (load_dump_addr) begin
			dump_addr_r <= general_pointer;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_r <= IDLE;
			index_r <= 4'h0;
			reset_after_r <= 1'b0;
			wr_valid_r <= 1'b0;
			wr_addr_r <= stats_pkg::ADDR_RESET;
			wr_data_r <= stats_pkg::COUNTER_RESET;
			dump_done_r <= 1'b0;
		end else begin
			dump_done_r <= 1'b0;
			case (state_r)
				IDLE: begin
					if (cmd_valid && (command_unit_opcode == stats_pkg::OPC_DUMP
						|| command_unit_opcode == stats_pkg::OPC_DUMP_RESET)) begin
						state_r <= READ; // R2
						index_r <= 4'h0;
						reset_after_r <= command_unit_opcode == stats_pkg::OPC_DUMP_RESET;
					end
				end
				READ: begin
					state_r <= WRITE;
				end
				WRITE: begin
					if (!wr_valid_r) begin
						wr_valid_r <= 1'b1;
						wr_addr_r <= word_addr(dump_addr_r, index_r); // R19
						wr_data_r <= ev.rd_data;
					end else if (wr_ready) begin
						wr_valid_r <= 1'b0;
						if (index_r == stats_pkg::IDX_LAST) begin
							state_r <= FINISH;
						end else begin
							index_r <= index_r + 4'h1;
							state_r <= READ;
						end
					end
				end
				FINISH: begin
					state_r <= IDLE;
					dump_done_r <= 1'b1;
				end
				default: begin
					state_r <= IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dump_busy <= 1'b0;
		end else begin
			dump_busy <= freeze || (cmd_valid && (command_unit_opcode == stats_pkg::OPC_DUMP
				|| command_unit_opcode == stats_pkg::OPC_DUMP_RESET));
		end
	end

	assign wr_valid = wr_valid_r;
	assign wr_addr = wr_addr_r;
	assign wr_data = wr_data_r;
	assign dump_done = dump_done_r;

	////////////////////////////////////////////////////////////////
	// checks
	property p_crc_align_excl;
		@(posedge core_clk) disable iff (reset)
		!(ev.inc[stats_pkg::IDX_CRC_ERR] && ev.inc[stats_pkg::IDX_ALIGN_ERR]);
	endproperty
	a_crc_align_excl: assert property (p_crc_align_excl) else $error("crc and align both counted"); // R15

	property p_short_blocks;
		@(posedge core_clk) disable iff (reset)
		(rx_done && rx_short) |-> !inc_nxt[stats_pkg::IDX_CRC_ERR] && !inc_nxt[stats_pkg::IDX_ALIGN_ERR];
	endproperty
	a_short_blocks: assert property (p_short_blocks) else $error("short frame counted as crc"); // R15

	property p_no_inc_while_dump;
		@(posedge core_clk) disable iff (reset)
		freeze |-> ev.inc == '0 && ev.coll_add == stats_pkg::COLL_ZERO;
	endproperty
	a_no_inc_while_dump: assert property (p_no_inc_while_dump) else $error("count moved mid dump"); // R20

	property p_held_applied;
		@(posedge core_clk) disable iff (reset)
		freeze && inc_nxt[stats_pkg::IDX_TX_GOOD] |-> ##[1:1000] ev.inc[stats_pkg::IDX_TX_GOOD];
	endproperty
	a_held_applied: assert property (p_held_applied) else $error("held event lost"); // R20

	property p_tx_good_end;
		@(posedge core_clk) disable iff (reset)
		!tx_done |-> !inc_nxt[stats_pkg::IDX_TX_GOOD] && !inc_nxt[stats_pkg::IDX_RETRY_LIMIT];
	endproperty
	a_tx_good_end: assert property (p_tx_good_end) else $error("tx counted outside frame end"); // R1

	property p_rx_good_end;
		@(posedge core_clk) disable iff (reset)
		!rx_done |-> !inc_nxt[stats_pkg::IDX_RX_GOOD];
	endproperty
	a_rx_good_end: assert property (p_rx_good_end) else $error("rx counted outside frame end"); // R12

	property p_single_multi;
		@(posedge core_clk) disable iff (reset)
		!(inc_nxt[stats_pkg::IDX_SINGLE_COL] && inc_nxt[stats_pkg::IDX_MULTI_COL]);
	endproperty
	a_single_multi: assert property (p_single_multi) else $error("single and multi both"); // R9

	property p_addr_step;
		@(posedge core_clk) disable iff (reset)
		$rose(wr_valid) |-> wr_addr == word_addr(dump_addr_r, index_r);
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("dump word address wrong"); // R19

	property p_clear_only_reset;
		@(posedge core_clk) disable iff (reset)
		ev.clear_all |-> reset_after_r ##1 dump_done;
	endproperty
	a_clear_only_reset: assert property (p_clear_only_reset) else $error("clear without reset dump"); // R19

	property p_wr_hold;
		@(posedge core_clk) disable iff (reset)
		wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("dump word moved before accept"); // R19

	property p_done_pulse;
		@(posedge core_clk) disable iff (reset)
		dump_done |=> !dump_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("dump done longer than a cycle"); // R19

	property p_cmd_starts;
		@(posedge core_clk) disable iff (reset)
		state_r == IDLE && cmd_valid
			&& (command_unit_opcode == stats_pkg::OPC_DUMP
			|| command_unit_opcode == stats_pkg::OPC_DUMP_RESET)
			|=> dump_busy && state_r == READ;
	endproperty
	a_cmd_starts: assert property (p_cmd_starts) else $error("dump command not taken"); // R2

	property p_other_ignored;
		@(posedge core_clk) disable iff (reset)
		state_r == IDLE && command_unit_opcode != stats_pkg::OPC_DUMP
			&& command_unit_opcode != stats_pkg::OPC_DUMP_RESET |=> state_r == IDLE;
	endproperty
	a_other_ignored: assert property (p_other_ignored) else $error("other opcode started dump"); // R2

	property p_idle_quiet;
		@(posedge core_clk) disable iff (reset)
		state_r == IDLE |-> !wr_valid;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("word offered outside a dump"); // R2

	property p_underrun_counted;
		@(posedge core_clk) disable iff (reset)
		tx_underrun && !freeze |-> ev.inc[stats_pkg::IDX_UNDERRUN];
	endproperty
	a_underrun_counted: assert property (p_underrun_counted) else $error("underrun not counted"); // R6

	property p_coll_added;
		@(posedge core_clk) disable iff (reset)
		tx_done && !freeze && held_coll_r == stats_pkg::COLL_ZERO |-> ev.coll_add == tx_collisions;
	endproperty
	a_coll_added: assert property (p_coll_added) else $error("collisions not added"); // R11

	property p_lost_needs_ok;
		@(posedge core_clk) disable iff (reset)
		inc_nxt[stats_pkg::IDX_LOST_CRS] |-> tx_done && tx_ok;
	endproperty
	a_lost_needs_ok: assert property (p_lost_needs_ok) else $error("lost carrier on failed frame"); // R7
endmodule // mac_statistics_counters
`default_nettype wire

// ===== dump_sink.sv
// memory-side model that accepts dump words, promptly or after a stall
`timescale 1ns/1ps
`default_nettype none
module dump_sink (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// dump write port
	input wire logic wr_valid,
	input wire logic [31:0] wr_addr,
	input wire logic [31:0] wr_data,
	output logic wr_ready,
	// wait cycles before accepting a word
	input wire logic [3:0] stall
);
	logic [31:0] got_addr[$];
	logic [31:0] got_data[$];
	logic [3:0] wait_r;
	////////////////////////////////////////////////////////////////
	// ready only after the word has stood for stall plus one cycles
	// plain always: the bench empties the queues between dumps
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_ready <= 1'b0;
			wait_r <= 4'h0;
		end else if (wr_ready && wr_valid) begin
			wr_ready <= 1'b0;
			wait_r <= 4'h0;
			got_addr.push_back(wr_addr);
			got_data.push_back(wr_data);
		end else if (wr_valid) begin
			if (wait_r == stall) wr_ready <= 1'b1;
			else wait_r <= wait_r + 4'h1;
		end
	end
endmodule // dump_sink
`default_nettype wire

// ===== mac_statistics_counters_test.sv
// self-checking bench for the statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module mac_statistics_counters_test;
	logic core_clk, reset, tx_done, tx_ok, tx_retry_limit, tx_late_collision, tx_lost_carrier;
	logic tx_deferred, tx_underrun, rx_done, rx_ok, rx_crc_error, rx_misaligned, rx_short;
	logic rx_symbol_error, load_dump_addr, cmd_valid, wr_valid, wr_ready, dump_busy, dump_done;
	logic [3:0] tx_collisions, command_unit_opcode, stall;
	logic [31:0] general_pointer, wr_addr, wr_data;
	logic [31:0] exp[12];
	int err_total, n_tests, cycles;
	localparam logic [31:0] BASE = 32'h00012340;
	mac_statistics_counters dut (.core_clk, .reset, .tx_done, .tx_ok, .tx_retry_limit,
		.tx_late_collision, .tx_lost_carrier, .tx_deferred, .tx_collisions, .tx_underrun,
		.rx_done, .rx_ok, .rx_crc_error, .rx_misaligned, .rx_short, .rx_symbol_error,
		.load_dump_addr, .general_pointer, .cmd_valid, .command_unit_opcode, .wr_valid,
		.wr_addr, .wr_data, .wr_ready, .dump_busy, .dump_done);
	dump_sink sink (.core_clk, .reset, .wr_valid, .wr_addr, .wr_data, .wr_ready, .stall);
	////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// hang guard, well above the several hundred cycles needed
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_total++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// flags: ok, retry limit, late collision, lost carrier, deferred
	task automatic tx_frame(input logic [4:0] f, input logic [3:0] col);
		@(posedge core_clk);
		{tx_done, tx_ok, tx_retry_limit, tx_late_collision, tx_lost_carrier, tx_deferred,
			tx_collisions} <= {1'b1, f, col};
		@(posedge core_clk);
		tx_done <= 1'b0;
	endtask
	// flags: ok, crc, misaligned, short, symbol error
	task automatic rx_frame(input logic [4:0] f);
		@(posedge core_clk);
		{rx_done, rx_ok, rx_crc_error, rx_misaligned, rx_short, rx_symbol_error} <= {1'b1, f};
		@(posedge core_clk);
		rx_done <= 1'b0;
	endtask
	// bump sends one good frame while the dump runs
	task automatic dump(input logic [3:0] opc, input logic [3:0] st, input logic bump);
		int n;
		@(posedge core_clk);
		{cmd_valid, command_unit_opcode, stall} <= {1'b1, opc, st};
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		if (bump) begin
			tx_frame(5'h10, 4'h0);
			chk("busy", 1, dump_busy);
		end
		n = 0;
		while (dump_done !== 1'b1 && n < 500) begin
			@(posedge core_clk);
			n++;
		end
		chk("done", 1, dump_done);
		chk("words", 12, sink.got_data.size());
		for (int i = 0; i < 12 && i < sink.got_data.size(); i++) begin
			chk("addr", BASE + 4 * i, sink.got_addr[i]);
			chk("data", exp[i], sink.got_data[i]);
		end
		sink.got_addr.delete();
		sink.got_data.delete();
		if (opc == 4'h7) exp = '{default: 0};
		exp[0] += bump;
		@(posedge core_clk);
		chk("idle", 0, dump_busy);
		chk("done", 0, dump_done);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset_dump;
		exp = '{default: 0};
		dump(4'h5, 4'h0, 1'b0);
	endtask
	task automatic t_tx;
		tx_frame(5'h10, 4'h0);
		tx_frame(5'h10, 4'h1);
		tx_frame(5'h13, 4'h3);
		tx_frame(5'h08, 4'hF);
		tx_frame(5'h04, 4'h1);
		repeat (3) begin
			@(posedge core_clk);
			tx_underrun <= 1'b1;
			@(posedge core_clk);
			tx_underrun <= 1'b0;
		end
		exp = '{3, 1, 1, 3, 1, 1, 1, 1, 20, 0, 0, 0};
		dump(4'h5, 4'h2, 1'b0);
	endtask
	task automatic t_rx;
		rx_frame(5'h10);
		rx_frame(5'h08);
		rx_frame(5'h0C);
		rx_frame(5'h0A);
		rx_frame(5'h01);
		rx_frame(5'h09);
		exp[9] = 1;
		exp[10] = 3;
		exp[11] = 1;
		dump(4'h7, 4'h5, 1'b0);
		dump(4'h5, 4'h0, 1'b0);
	endtask
	task automatic t_during_dump;
		dump(4'h7, 4'h3, 1'b1);
		dump(4'h5, 4'h1, 1'b0);
	endtask
	// reset in mid run wipes counts and the dump base
	task automatic t_mid_reset;
		tx_frame(5'h10, 4'h2);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		chk("busy", 0, dump_busy);
		load_dump_addr <= 1'b1;
		@(posedge core_clk);
		load_dump_addr <= 1'b0;
		exp = '{default: 0};
		dump(4'h5, 4'h0, 1'b0);
	endtask
	// only the two dump opcodes may start a dump
	task automatic t_other_opcodes;
		for (int op = 0; op < 16; op++) begin
			if (op == 5 || op == 7) continue;
			@(posedge core_clk);
			{cmd_valid, command_unit_opcode} <= {1'b1, 4'(op)};
			@(posedge core_clk);
			cmd_valid <= 1'b0;
			repeat (3) @(posedge core_clk);
			chk("busy", 0, dump_busy);
			chk("wr_valid", 0, wr_valid);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{tx_done, tx_ok, tx_retry_limit, tx_late_collision, tx_lost_carrier, tx_deferred} = '0;
		{tx_underrun, rx_done, rx_ok, rx_crc_error, rx_misaligned, rx_short} = '0;
		{rx_symbol_error, load_dump_addr, cmd_valid, tx_collisions} = '0;
		{command_unit_opcode, stall} = '0;
		general_pointer = BASE;
		reset = 1'b1;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		load_dump_addr <= 1'b1;
		@(posedge core_clk);
		load_dump_addr <= 1'b0;
		t_reset_dump();
		t_tx();
		t_rx();
		t_during_dump();
		t_mid_reset();
		t_other_opcodes();
		give_verdict();
	end
endmodule // mac_statistics_counters_test
`default_nettype wire
